// file: common/spc_pkg.sv
// Shared constants, types and register map of the segment privilege checker
package spc_pkg;

  // ****************************************************************
  // Widths and privilege encoding
  // ****************************************************************
  localparam int SPC_AXI_AW = 12;
  localparam int SPC_DW = 32;
  localparam int SPC_PLW = 2;
  localparam int SPC_PORT_W = 16;
  localparam int SPC_BIT_IDX_W = 5;
  localparam logic [SPC_PLW-1:0] SPC_PL_MOST = 2'h0;
  localparam logic [SPC_PLW-1:0] SPC_PL_LEAST = 2'h3;
  localparam int SPC_IOMAP_WORDS_DEF = 32;
  localparam logic [SPC_DW-1:0] SPC_IOMAP_RESET = 32'hFFFFFFFF;

  // ****************************************************************
  // Register offsets and fields
  // ****************************************************************
  localparam logic [SPC_AXI_AW-1:0] SPC_OFS_CTRL_ZERO = 12'h000;
  localparam logic [SPC_AXI_AW-1:0] SPC_OFS_FLAGS = 12'h004;
  localparam logic [SPC_AXI_AW-1:0] SPC_OFS_TASK = 12'h008;
  localparam logic [SPC_AXI_AW-1:0] SPC_OFS_STATUS = 12'h00C;
  localparam logic [SPC_AXI_AW-1:0] SPC_OFS_IOMAP = 12'h100;
  localparam int SPC_BIT_PROT_EN = 0;
  localparam int SPC_BIT_INTR_EN = 9;
  localparam int SPC_LSB_IO_THR = 12;
  localparam int SPC_BIT_NESTED = 14;
  localparam int SPC_BIT_TASK32 = 0;
  localparam int SPC_LSB_ST_PRIV = 0;
  localparam int SPC_BIT_ST_PROT = 2;
  localparam int SPC_LSB_ST_CAUSE = 4;
  localparam int SPC_LSB_ST_FAULTS = 8;
  localparam logic [SPC_DW-1:0] SPC_WORD_ZERO = 32'h00000000;

  // ****************************************************************
  // Bus answers and fault causes
  // ****************************************************************
  localparam logic [1:0] SPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SPC_RESP_SLVERR = 2'h2;
  localparam logic [3:0] SPC_CAUSE_NONE = 4'h0;
  localparam logic [3:0] SPC_CAUSE_PRIV = 4'h1;
  localparam logic [3:0] SPC_CAUSE_TYPE = 4'h2;
  localparam logic [3:0] SPC_CAUSE_IO = 4'h3;
  localparam logic [3:0] SPC_CAUSE_TARGET = 4'h4;
  localparam logic [7:0] SPC_FAULT_ONE = 8'h01;

  // ****************************************************************
  // Operations, descriptor kinds, tables, states
  // ****************************************************************
  typedef enum logic [2:0] {
    SPC_OP_DATA, SPC_OP_IO_PORT, SPC_OP_IO_FLAG, SPC_OP_JMP,
    SPC_OP_CALL, SPC_OP_RET, SPC_OP_IRET, SPC_OP_INT
  } spc_op_t;
  typedef enum logic [2:0] {
    SPC_DT_DATA, SPC_DT_CODE, SPC_DT_CALL_GATE, SPC_DT_TRAP_GATE,
    SPC_DT_INT_GATE, SPC_DT_TASK_BLOCK, SPC_DT_TASK_GATE
  } spc_desc_t;
  typedef enum logic [1:0] {
    SPC_TBL_GLOBAL, SPC_TBL_LOCAL, SPC_TBL_INTERRUPT
  } spc_tbl_t;
  typedef enum logic {SPC_IDLE, SPC_LOOK} spc_fsm_t;

  typedef struct packed {
    spc_fsm_t st;
    logic protection_enable_bit;
    logic [SPC_PLW-1:0] current_priv_level;
    logic [SPC_PLW-1:0] io_priv_threshold;
    logic nested_task_flag;
    logic intr_enable;
    logic task_block_32;
    logic [3:0] cause;
    logic [7:0] faults;
    logic aw_have;
    logic [SPC_AXI_AW-1:0] aw_addr;
    logic w_have;
    logic [SPC_DW-1:0] w_data;
    logic [SPC_DW/8-1:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [SPC_DW-1:0] rdata;
    logic req_ready;
    logic resp_valid;
    logic resp_fault;
    logic [SPC_PLW-1:0] resp_priv;
    logic stack_load;
    logic [SPC_PLW-1:0] stack_level;
    logic stack_restore;
    logic [SPC_BIT_IDX_W-1:0] lk_bit;
    logic lk_out_of_range;
  } spc_state_t;

endpackage

// file: hdl/spc_priv_cmp.sv
// Privilege comparator: ordering test and less privileged of two levels
`timescale 1ns/1ps
module spc_priv_cmp #(
  parameter int W = 2
) (
  // Levels to compare
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  // Results
  output logic a_le_b,
  output logic [W-1:0] larger
);

  // Numerically larger means less privileged
  assign a_le_b = (a <= b);
  assign larger = (a > b) ? a : b;

endmodule

// file: hdl/spc_iomap_mem.sv
// Port permission bitmap memory with registered read data
`timescale 1ns/1ps
module spc_iomap_mem
  import spc_pkg::*;
#(
  parameter int WORDS = SPC_IOMAP_WORDS_DEF,
  parameter int DW = SPC_DW,
  parameter int AW = $clog2(WORDS)
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write port
  input wire logic we,
  input wire logic [DW/8-1:0] wstrb,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem_q [WORDS];

  // Reset denies every port, so a stale map never grants access
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_q[i] <= SPC_IOMAP_RESET;
      end
      rdata <= SPC_IOMAP_RESET;
    end else begin
      for (int b = 0; b < DW/8; b++) begin
        if (we && wstrb[b]) begin
          mem_q[waddr][b*8 +: 8] <= wdata[b*8 +: 8];
        end
      end
      rdata <= mem_q[raddr];
    end
  end

endmodule

// file: hdl/spc_checker.sv
// Segment privilege checker: access, port and transfer checks, AXI4-Lite
`timescale 1ns/1ps
module spc_checker
  import spc_pkg::*;
#(
  parameter int IOMAP_WORDS = SPC_IOMAP_WORDS_DEF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [SPC_AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [SPC_DW-1:0] s_axi_wdata,
  input wire logic [SPC_DW/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [SPC_AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [SPC_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Check request from the execution core
  input wire logic req_valid,
  output logic req_ready,
  input wire spc_op_t req_op,
  input wire spc_desc_t req_desc_type,
  input wire spc_tbl_t req_table,
  input wire logic [SPC_PLW-1:0] req_requested_priv_level,
  input wire logic [SPC_PLW-1:0] req_descriptor_priv_level,
  input wire logic [SPC_PLW-1:0] req_target_priv_level,
  input wire logic [SPC_PORT_W-1:0] req_port,
  input wire logic req_set_intr,
  // Check answer
  output logic resp_valid,
  output logic resp_gp_fault,
  output logic [SPC_PLW-1:0] resp_current_priv_level,
  // Stack switching
  output logic stack_load,
  output logic [SPC_PLW-1:0] stack_level,
  output logic stack_restore,
  // Mode and flag state
  output logic protected_mode,
  output logic [SPC_PLW-1:0] current_priv_level,
  output logic intr_enable
);

  localparam int MAW = $clog2(IOMAP_WORDS);
  localparam int IDXW = SPC_AXI_AW - 2;
  localparam int WIDXW = SPC_PORT_W - SPC_BIT_IDX_W;
  localparam logic [IDXW-1:0] IOMAP_BASE = SPC_OFS_IOMAP[SPC_AXI_AW-1:2];
  localparam logic [IDXW-1:0] IOMAP_LEN = IDXW'(IOMAP_WORDS);
  localparam logic [WIDXW-1:0] PORT_WORDS = WIDXW'(IOMAP_WORDS);

  spc_state_t s_q;
  spc_state_t s_d;

  logic [SPC_PLW-1:0] effective_priv_level;
  logic eff_le_desc;
  logic cur_le_thr;
  logic tgt_le_cur;
  logic cur_le_req;
  logic mem_we;
  logic [MAW-1:0] mem_waddr;
  logic [MAW-1:0] mem_raddr;
  logic [SPC_DW-1:0] mem_rdata;
  logic [IDXW-1:0] widx;

  // ****************************************************************
  // Privilege arithmetic
  // ****************************************************************
  // Real mode starts at level zero unless a check is granted in the same cycle, and the checks that use these comparisons are skipped there
  spc_priv_cmp #(.W(SPC_PLW)) u_eff (
    .a(req_requested_priv_level),
    .b(s_q.current_priv_level),
    .a_le_b(),
    .larger(effective_priv_level)
  );
  spc_priv_cmp #(.W(SPC_PLW)) u_acc (
    .a(effective_priv_level),
    .b(req_descriptor_priv_level),
    .a_le_b(eff_le_desc),
    .larger()
  );
  spc_priv_cmp #(.W(SPC_PLW)) u_thr (
    .a(s_q.current_priv_level),
    .b(s_q.io_priv_threshold),
    .a_le_b(cur_le_thr),
    .larger()
  );
  spc_priv_cmp #(.W(SPC_PLW)) u_tgt (
    .a(req_target_priv_level),
    .b(s_q.current_priv_level),
    .a_le_b(tgt_le_cur),
    .larger()
  );
  spc_priv_cmp #(.W(SPC_PLW)) u_ret (
    .a(s_q.current_priv_level),
    .b(req_requested_priv_level),
    .a_le_b(cur_le_req),
    .larger()
  );

  spc_iomap_mem #(.WORDS(IOMAP_WORDS), .DW(SPC_DW), .AW(MAW)) u_map (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(mem_we),
    .wstrb(s_q.w_strb),
    .waddr(mem_waddr),
    .wdata(s_q.w_data),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic tfault;
    logic pfault;
    logic lookup;
    logic chg;
    logic [SPC_PLW-1:0] new_pl;
    logic ld;
    logic rs;
    logic [SPC_DW-1:0] rd;
    logic [IDXW-1:0] ridx;
    tfault = 1'b0;
    pfault = 1'b0;
    lookup = 1'b0;
    chg = 1'b0;
    new_pl = s_q.current_priv_level;
    ld = 1'b0;
    rs = 1'b0;
    rd = SPC_WORD_ZERO;
    ridx = s_axi_araddr[SPC_AXI_AW-1:2] - IOMAP_BASE;
    s_d = s_q;
    mem_we = 1'b0;
    widx = s_q.aw_addr[SPC_AXI_AW-1:2] - IOMAP_BASE;
    mem_waddr = widx[MAW-1:0];
    mem_raddr = req_port[SPC_BIT_IDX_W +: MAW];
    s_d.resp_valid = 1'b0;
    s_d.resp_fault = 1'b0;
    s_d.stack_load = 1'b0;
    s_d.stack_restore = 1'b0;

    // Bus: address and data are taken independently
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = SPC_RESP_OKAY;
      if (s_q.aw_addr == SPC_OFS_CTRL_ZERO) begin
        if (s_q.w_strb[0]) begin
          s_d.protection_enable_bit = s_q.w_data[SPC_BIT_PROT_EN];
          if (!s_q.w_data[SPC_BIT_PROT_EN]) begin
            s_d.current_priv_level = SPC_PL_MOST;
          end
        end
      end else if (s_q.aw_addr == SPC_OFS_FLAGS) begin
        // Interrupt enable is read-only here; only checked ops change it
        if (s_q.w_strb[1]) begin
          s_d.io_priv_threshold =
            s_q.w_data[SPC_LSB_IO_THR +: SPC_PLW];
          s_d.nested_task_flag = s_q.w_data[SPC_BIT_NESTED];
        end
      end else if (s_q.aw_addr == SPC_OFS_TASK) begin
        if (s_q.w_strb[0]) begin
          s_d.task_block_32 = s_q.w_data[SPC_BIT_TASK32];
        end
      end else if (s_q.aw_addr == SPC_OFS_STATUS) begin
        s_d.bresp = SPC_RESP_OKAY;
      end else if (widx < IOMAP_LEN && s_q.aw_addr[1:0] == 2'h0) begin
        mem_we = 1'b1;
      end else begin
        s_d.bresp = SPC_RESP_SLVERR;
      end
    end
    s_d.awready = !s_d.aw_have;
    s_d.wready = !s_d.w_have;

    // Bus: read answer one cycle after the address is taken
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = SPC_RESP_OKAY;
      if (s_axi_araddr == SPC_OFS_CTRL_ZERO) begin
        rd[SPC_BIT_PROT_EN] = s_q.protection_enable_bit;
      end else if (s_axi_araddr == SPC_OFS_FLAGS) begin
        rd[SPC_BIT_INTR_EN] = s_q.intr_enable;
        rd[SPC_LSB_IO_THR +: SPC_PLW] = s_q.io_priv_threshold;
        rd[SPC_BIT_NESTED] = s_q.nested_task_flag;
      end else if (s_axi_araddr == SPC_OFS_TASK) begin
        rd[SPC_BIT_TASK32] = s_q.task_block_32;
      end else if (s_axi_araddr == SPC_OFS_STATUS) begin
        rd[SPC_LSB_ST_PRIV +: SPC_PLW] = s_q.current_priv_level;
        rd[SPC_BIT_ST_PROT] = s_q.protection_enable_bit;
        rd[SPC_LSB_ST_CAUSE +: 4] = s_q.cause;
        rd[SPC_LSB_ST_FAULTS +: 8] = s_q.faults;
      end else if (ridx < IOMAP_LEN && s_axi_araddr[1:0] == 2'h0) begin
        // Bitmap is write-only from the bus; its read port serves checks
        rd = SPC_WORD_ZERO;
      end else begin
        s_d.rresp = SPC_RESP_SLVERR;
      end
      s_d.rdata = rd;
    end
    s_d.arready = !s_d.rvalid;

    // Checks
    case (s_q.st)
      SPC_IDLE: begin
        if (req_valid) begin
          if (!s_q.protection_enable_bit) begin
            // Real mode: no protection checks, privilege level left unchanged
            if (req_op == SPC_OP_IO_FLAG) begin
              s_d.intr_enable = req_set_intr;
            end
          end else begin
            case (req_op)
              SPC_OP_DATA: begin
                tfault = (req_desc_type != SPC_DT_DATA);
                pfault = !eff_le_desc;
              end
              SPC_OP_IO_PORT: begin
                if (!cur_le_thr && !s_q.task_block_32) begin
                  pfault = 1'b1;
                end else if (!cur_le_thr) begin
                  lookup = 1'b1;
                end
              end
              SPC_OP_IO_FLAG: begin
                pfault = !cur_le_thr;
              end
              SPC_OP_JMP, SPC_OP_CALL: begin
                if (req_desc_type == SPC_DT_CODE) begin
                  tfault = (req_table == SPC_TBL_INTERRUPT);
                  pfault = (req_target_priv_level !=
                            s_q.current_priv_level);
                end else if (req_desc_type == SPC_DT_CALL_GATE &&
                             req_op == SPC_OP_CALL) begin
                  tfault = (req_table == SPC_TBL_INTERRUPT);
                  pfault = !eff_le_desc || !tgt_le_cur;
                  chg = 1'b1;
                  ld = !(req_target_priv_level ==
                         s_q.current_priv_level);
                end else if (req_desc_type == SPC_DT_TASK_BLOCK) begin
                  tfault = (req_table != SPC_TBL_GLOBAL);
                  pfault = !eff_le_desc;
                  chg = 1'b1;
                end else if (req_desc_type == SPC_DT_TASK_GATE) begin
                  tfault = (req_table == SPC_TBL_INTERRUPT);
                  pfault = !eff_le_desc;
                  chg = 1'b1;
                end else begin
                  tfault = 1'b1;
                end
              end
              SPC_OP_RET, SPC_OP_IRET: begin
                if (req_op == SPC_OP_IRET && s_q.nested_task_flag) begin
                  tfault = (req_desc_type != SPC_DT_TASK_GATE) ||
                           (req_table != SPC_TBL_INTERRUPT);
                  chg = 1'b1;
                end else begin
                  tfault = (req_desc_type != SPC_DT_CODE) ||
                           (req_table == SPC_TBL_INTERRUPT);
                  pfault = !cur_le_req;
                  rs = (req_requested_priv_level !=
                        s_q.current_priv_level);
                end
              end
              default: begin
                if (req_desc_type == SPC_DT_TRAP_GATE ||
                    req_desc_type == SPC_DT_INT_GATE) begin
                  tfault = (req_table != SPC_TBL_INTERRUPT);
                  pfault = !eff_le_desc || !tgt_le_cur;
                  chg = 1'b1;
                  ld = !(req_target_priv_level ==
                         s_q.current_priv_level);
                end else if (req_desc_type == SPC_DT_TASK_GATE) begin
                  tfault = (req_table != SPC_TBL_INTERRUPT);
                  pfault = !eff_le_desc;
                  chg = 1'b1;
                end else begin
                  tfault = 1'b1;
                end
              end
            endcase
            if (rs) begin
              new_pl = req_requested_priv_level;
            end else if (chg) begin
              new_pl = req_target_priv_level;
            end
          end
          if (lookup) begin
            s_d.st = SPC_LOOK;
            s_d.req_ready = 1'b0;
            s_d.lk_bit = req_port[SPC_BIT_IDX_W-1:0];
            s_d.lk_out_of_range =
              (req_port[SPC_PORT_W-1:SPC_BIT_IDX_W] >= PORT_WORDS);
          end else begin
            s_d.resp_valid = 1'b1;
            s_d.resp_fault = tfault || pfault;
            if (tfault || pfault) begin
              s_d.cause = tfault ? SPC_CAUSE_TYPE :
                          (chg && !tgt_le_cur) ? SPC_CAUSE_TARGET :
                          SPC_CAUSE_PRIV;
              s_d.faults = s_q.faults + SPC_FAULT_ONE;
            end else begin
              // Only granted transfers move privilege or the stack
              s_d.current_priv_level = new_pl;
              s_d.stack_load = ld;
              s_d.stack_level = req_target_priv_level;
              s_d.stack_restore = rs;
              if (req_op == SPC_OP_IO_FLAG) begin
                s_d.intr_enable = req_set_intr;
              end
            end
            s_d.resp_priv = s_d.current_priv_level;
          end
        end
      end
      default: begin
        // Bitmap bit set, or port past the map, refuses the port
        s_d.st = SPC_IDLE;
        s_d.req_ready = 1'b1;
        s_d.resp_valid = 1'b1;
        s_d.resp_priv = s_q.current_priv_level;
        if (s_q.lk_out_of_range || mem_rdata[s_q.lk_bit]) begin
          s_d.resp_fault = 1'b1;
          s_d.cause = SPC_CAUSE_IO;
          s_d.faults = s_q.faults + SPC_FAULT_ONE;
        end
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.st <= SPC_IDLE;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.req_ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign req_ready = s_q.req_ready;
  assign resp_valid = s_q.resp_valid;
  assign resp_gp_fault = s_q.resp_fault;
  assign resp_current_priv_level = s_q.resp_priv;
  assign stack_load = s_q.stack_load;
  assign stack_level = s_q.stack_level;
  assign stack_restore = s_q.stack_restore;
  assign protected_mode = s_q.protection_enable_bit;
  assign current_priv_level = s_q.current_priv_level;
  assign intr_enable = s_q.intr_enable;

endmodule

// file: tb/spc_core_model.sv
// Execution core stand-in that issues check requests
`timescale 1ns/1ps
module spc_core_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Handshake
  input wire logic start,
  input wire logic req_ready,
  output logic req_valid
);
  // Held until a ready edge; never withdrawn early
  always_ff @(posedge aclk) begin
    if (!aresetn) req_valid <= 1'b0;
    else if (start) req_valid <= 1'b1;
    else if (req_ready) req_valid <= 1'b0;
  end
endmodule

// file: tb/spc_checker_assertions.sv
// Port assertions for the segment privilege checker
`timescale 1ns/1ps
module spc_checker_assertions (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Check port
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire logic resp_gp_fault,
  input wire logic [1:0] resp_current_priv_level,
  input wire logic stack_load,
  input wire logic [1:0] stack_level,
  input wire logic stack_restore,
  input wire logic protected_mode,
  input wire logic [1:0] current_priv_level
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_resp_bound: assert property (
    req_valid && req_ready |-> ##[1:2] resp_valid) else $error("no answer");
  chk_fault_idle: assert property (
    !resp_valid |-> !resp_gp_fault) else $error("stray fault");
  chk_real_zero: assert property (
    !protected_mode |-> current_priv_level == 2'h0) else $error("real lvl");
  chk_fault_still: assert property (
    resp_valid && resp_gp_fault |-> $stable(current_priv_level)
    && !stack_load && !stack_restore) else $error("fault had effect");
  chk_level_echo: assert property (
    resp_valid |-> resp_current_priv_level == current_priv_level)
    else $error("level echo");
  chk_stack_level: assert property (
    stack_load |-> stack_level == current_priv_level && stack_level != 2'h3)
    else $error("stack level");
  chk_stack_change: assert property (
    stack_load || stack_restore |->
    current_priv_level != $past(current_priv_level)) else $error("stack");
  chk_level_quiet: assert property (
    !resp_valid && protected_mode && $past(protected_mode) |->
    $stable(current_priv_level)) else $error("level moved");
  cover property (stack_load);
  cover property (stack_restore);
  cover property (resp_valid && resp_gp_fault);
endmodule
bind spc_checker spc_checker_assertions spc_checker_assertions_i (.*);

// file: tb/segment_privilege_checker_test.sv
// Self-checking bench for the segment privilege checker
`timescale 1ns/1ps
module segment_privilege_checker_test;
  import spc_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, req_valid, req_set_intr, start;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, req_ready, resp_valid, resp_gp_fault;
  logic stack_load, stack_restore, protected_mode, intr_enable;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, m0;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, req_requested_priv_level;
  logic [1:0] req_descriptor_priv_level, req_target_priv_level;
  logic [1:0] resp_current_priv_level, stack_level, current_priv_level;
  logic [15:0] req_port;
  spc_op_t req_op = SPC_OP_DATA;
  spc_desc_t req_desc_type = SPC_DT_DATA;
  spc_tbl_t req_table = SPC_TBL_GLOBAL;
  int fail_count, n_checks, cur, thr, t32, pm, ie, cyc, nt;
  spc_checker spc_checker_i (.*);
  spc_core_model spc_core_model_i (.*);
  // ****************************************
  // Clock, timeout, helpers
  // ****************************************
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    cmp("bresp", s_axi_bresp, r);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, logic [1:0] r);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    cmp("rresp", s_axi_rresp, r);
    cmp("rdata", s_axi_rdata, d);
    @(posedge aclk);
  endtask
  // Reference model of one check, then compare with the answer
  task automatic run(input int op, dt, tb, rp, dp, tg, pt, si);
    int e, f, nl, ld, rs;
    req_op <= spc_op_t'(op);
    req_desc_type <= spc_desc_t'(dt);
    req_table <= spc_tbl_t'(tb);
    req_requested_priv_level <= 2'(rp);
    req_descriptor_priv_level <= 2'(dp);
    req_target_priv_level <= 2'(tg);
    req_port <= 16'(pt);
    req_set_intr <= si[0];
    start <= 1;
    @(posedge aclk) start <= 0;
    e = rp > cur ? rp : cur;
    case (op)
      0: f = dt != 0 || e > dp;
      1: f = cur > thr && (t32 == 0 || pt > 31 || m0[pt] == 1);
      2: f = cur > thr;
      3, 4: f = dt == 1 ? tb == 2 || tg != cur :
        dt == 2 && op == 4 ? tb == 2 || e > dp || tg > cur :
        dt == 5 ? tb != 0 || e > dp : dt != 6 || tb == 2 || e > dp;
      7: f = dt == 3 || dt == 4 ? tb != 2 || e > dp || tg > cur :
        dt != 6 || tb != 2 || e > dp;
      default: f = op == 6 && nt ? dt != 6 || tb != 2 :
        dt != 1 || tb == 2 || cur > rp;
    endcase
    if (pm == 0) f = 0;
    rs = op == 5 || op == 6 && nt == 0;
    nl = cur;
    if (!f && pm && (op == 3 || op == 4 || op == 7 || op == 6 && nt)) nl = tg;
    if (!f && pm && rs) nl = rp;
    if (!f && op == 2) ie = si;
    ld = nl != cur && (op == 4 && dt == 2 || op == 7 && dt > 2 && dt < 5);
    do @(posedge aclk); while (resp_valid !== 1'b1);
    cmp("fault", resp_gp_fault, f);
    cmp("level", current_priv_level, nl);
    cmp("resp_lvl", resp_current_priv_level, nl);
    cmp("load", stack_load, ld);
    if (ld) cmp("stk_lvl", stack_level, nl);
    cmp("restore", stack_restore, rs && nl != cur);
    cmp("intr", intr_enable, ie);
    cur = nl;
  endtask
  task automatic burst(input int n);
    for (int i = 0; i < n; i++) begin
      run($urandom_range(0, 7), $urandom_range(0, 6), $urandom_range(0, 2),
        $urandom_range(0, 3), $urandom_range(0, 3), $urandom_range(0, 3),
        $urandom_range(0, 35), $urandom_range(0, 1));
    end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, start, req_set_intr} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 30'h0;
    {s_axi_wdata, req_port, req_requested_priv_level} = 50'h0;
    {req_descriptor_priv_level, req_target_priv_level} = 4'h0;
    s_axi_wstrb = 4'hF;
    void'($urandom(32'h065f6ffa));
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    cmp("mode", protected_mode, 0);
    burst(30);
    wr(SPC_OFS_CTRL_ZERO, 32'h00000001, SPC_RESP_OKAY);
    pm = 1;
    rd(SPC_OFS_STATUS, 32'h00000004, SPC_RESP_OKAY);
    rd(12'h010, 32'h00000000, SPC_RESP_SLVERR);
    wr(12'h006, 32'h00000001, SPC_RESP_SLVERR);
    burst(300);
    m0 = $urandom;
    thr = $urandom_range(0, 2);
    nt = $urandom_range(0, 1);
    t32 = 1;
    wr(SPC_OFS_IOMAP, m0, SPC_RESP_OKAY);
    wr(SPC_OFS_TASK, 32'h00000001, SPC_RESP_OKAY);
    wr(SPC_OFS_FLAGS, (32'(thr) << SPC_LSB_IO_THR) |
      (32'(nt) << SPC_BIT_NESTED), SPC_RESP_OKAY);
    burst(300);
    rd(SPC_OFS_FLAGS, (32'(thr) << SPC_LSB_IO_THR) |
      (32'(nt) << SPC_BIT_NESTED) | (32'(ie) << SPC_BIT_INTR_EN),
      SPC_RESP_OKAY);
    stop_test();
  end
endmodule
